// ---- logic/cio_map.svh ----
`ifndef CIO_MAP_SVH
`define CIO_MAP_SVH

// Register byte offsets
`define CIO_OFS_CONFIG 8'h00
`define CIO_OFS_FUNC 8'h04
`define CIO_OFS_RUNSRC 8'h08
`define CIO_OFS_STATUS 8'h0c

// CONFIG fields
`define CIO_CFG_A_DIR 0
`define CIO_CFG_B_DIR 1
`define CIO_CFG_A_POL 2
`define CIO_CFG_B_POL 3
`define CIO_CFG_R1_POL 4
`define CIO_CFG_R2_POL 5
`define CIO_CFG_W 6
`define CIO_CFG_RESET 6'h2a

// FUNC fields: four 4-bit selectors, port a at the bottom
`define CIO_FUNC_W 4
`define CIO_FUNC_A_LSB 0
`define CIO_FUNC_B_LSB 4
`define CIO_FUNC_R1_LSB 8
`define CIO_FUNC_R2_LSB 12
`define CIO_FUNC_RESET 16'h7350

// RUNSRC field
`define CIO_RUNSRC_W 3
`define CIO_RUNSRC_RESET 3'h0

// STATUS fields
`define CIO_ST_RUN 0
`define CIO_ST_A_IN 1
`define CIO_ST_B_IN 2
`define CIO_ST_A_OUT 3
`define CIO_ST_B_OUT 4
`define CIO_ST_R1 5
`define CIO_ST_R2 6

`endif

// ---- logic/cio_pkg.sv ----
package cio_pkg;

   typedef enum logic [3:0] {
      FN_CONST0 = 4'h0,
      FN_CONST1 = 4'h1,
      FN_OPERATING = 4'h2,
      FN_STANDBY = 4'h3,
      FN_FULL_LOAD = 4'h4,
      FN_DERATING = 4'h5,
      FN_TEMP_DERATING = 4'h6,
      FN_GLOBAL_ERROR = 4'h7,
      FN_RUN_COMMAND = 4'h8,
      FN_ERROR_ACK = 4'h9
   } func_t;

   typedef enum logic [2:0] {
      RS_TERMINAL = 3'h0,
      RS_FORCED_ON = 3'h1,
      RS_FORCED_OFF = 3'h2,
      RS_LOCAL_SWITCH = 3'h3,
      RS_SYNC_LINK = 3'h4
   } run_src_t;

endpackage : cio_pkg

// ---- logic/output_drive.sv ----
`timescale 1ns/1ps

module output_drive (
   // Clock and reset
   input wire logic clock_i,
   input wire logic srst_i,
   // Selection
   input wire logic [15:0] source_i,
   input wire logic [3:0] select_i,
   input wire logic invert_i,
   // Drive
   output logic drive_o
);

   logic active;
   logic drive_q;

   // Codes above the last function pick a zero entry of the source vector
   assign active = source_i[select_i];

   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         drive_q <= 1'b0;
      end else begin
         drive_q <= active ^ invert_i;
      end
   end

   assign drive_o = drive_q;

endmodule : output_drive

// ---- logic/customer_io_function_mux.sv ----
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "cio_map.svh"

// Summary of operation
// - Each digital port has a direction bit, 0 input, 1 output.
// - Input ports read high as asserted; low or open reads deasserted.
// - Output ports drive their selected function: constants, one status signal, the run command or the acknowledge input level.
// - Digital output polarity bit 1 drives high when active, 0 drives low.
// - Each relay has its own selector from the same list; active closes it.
// - Relay polarity 0 is normally open, 1 inverts to normally closed.
// - Run command source selectable: terminal (default), forced on/off, local switch, sync link.
//
module customer_io_function_mux (
   // Clock and reset
   input wire logic clock_i,
   input wire logic srst_i,
   // Register port
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   // Internal status
   input wire logic operating_i,
   input wire logic standby_i,
   input wire logic full_load_i,
   input wire logic derating_i,
   input wire logic temp_derating_i,
   input wire logic global_error_i,
   input wire logic sync_link_run_i,
   // Local switch pin
   input wire logic local_switch_i,
   // Customer ports
   input wire logic customer_port_a_i,
   output logic customer_port_a_o,
   output logic customer_port_a_oe_o,
   input wire logic customer_port_b_i,
   output logic customer_port_b_o,
   output logic customer_port_b_oe_o,
   // Relays, high means contact closed
   output logic relay_output_one_o,
   output logic relay_output_two_o,
   // Commands to the unit
   output logic run_cmd_o,
   output logic error_ack_o
);

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   logic [`CIO_CFG_W-1:0] config_q;
   logic [15:0] func_q;
   logic [`CIO_RUNSRC_W-1:0] runsrc_q;
   logic [31:0] rdata_q;

   wire sel_cfg = addr_i == `CIO_OFS_CONFIG;
   wire sel_func = addr_i == `CIO_OFS_FUNC;
   wire sel_runsrc = addr_i == `CIO_OFS_RUNSRC;
   wire sel_status = addr_i == `CIO_OFS_STATUS;
   // Writes to unmapped or read-only offsets are dropped
   wire wr_cfg = wr_i && sel_cfg;
   wire wr_func = wr_i && sel_func;
   wire wr_runsrc = wr_i && sel_runsrc;

   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         config_q <= `CIO_CFG_RESET;
      end else if (wr_cfg) begin
         config_q <= wdata_i[`CIO_CFG_W-1:0];
      end
   end

   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         func_q <= `CIO_FUNC_RESET;
      end else if (wr_func) begin
         func_q <= wdata_i[15:0];
      end
   end

   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         runsrc_q <= `CIO_RUNSRC_RESET;
      end else if (wr_runsrc) begin
         runsrc_q <= wdata_i[`CIO_RUNSRC_W-1:0];
      end
   end

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   logic [2:0] pin_meta_q;
   logic [2:0] pin_q;

   // Pins are asynchronous to the clock; only the second stage is read
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         pin_meta_q <= 3'h0;
         pin_q <= 3'h0;
      end else begin
         pin_meta_q <= {local_switch_i, customer_port_b_i, customer_port_a_i};
         pin_q <= pin_meta_q;
      end
   end

   // ------------------------------------------------------------
   // Input functions
   // ------------------------------------------------------------
   // An open pin is pulled low outside, so only a high level asserts
   wire a_dir = config_q[`CIO_CFG_A_DIR];
   wire b_dir = config_q[`CIO_CFG_B_DIR];
   wire [3:0] a_fn = func_q[`CIO_FUNC_A_LSB +: `CIO_FUNC_W];
   wire [3:0] b_fn = func_q[`CIO_FUNC_B_LSB +: `CIO_FUNC_W];
   wire a_in = !a_dir && pin_q[0];
   wire b_in = !b_dir && pin_q[1];
   wire a_is_run = a_fn == cio_pkg::FN_RUN_COMMAND;
   wire b_is_run = b_fn == cio_pkg::FN_RUN_COMMAND;
   wire a_is_ack = a_fn == cio_pkg::FN_ERROR_ACK;
   wire b_is_ack = b_fn == cio_pkg::FN_ERROR_ACK;
   wire term_run = (a_in && a_is_run) || (b_in && b_is_run);
   wire ack_level = (a_in && a_is_ack) || (b_in && b_is_ack);

   logic run_d;
   logic run_q;
   logic ack_prev_q;
   logic ack_q;

   // Unused source codes fall back to the terminal strip
   always_comb begin
      unique case (cio_pkg::run_src_t'(runsrc_q))
         cio_pkg::RS_TERMINAL: run_d = term_run;
         cio_pkg::RS_FORCED_ON: run_d = 1'b1;
         cio_pkg::RS_FORCED_OFF: run_d = 1'b0;
         cio_pkg::RS_LOCAL_SWITCH: run_d = pin_q[2];
         cio_pkg::RS_SYNC_LINK: run_d = sync_link_run_i;
         default: run_d = term_run;
      endcase
   end

   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         run_q <= 1'b0;
      end else begin
         run_q <= run_d;
      end
   end

   // Acknowledge fires once per rising edge so a held input does not repeat it
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         ack_prev_q <= 1'b0;
         ack_q <= 1'b0;
      end else begin
         ack_prev_q <= ack_level;
         ack_q <= ack_level && !ack_prev_q;
      end
   end

   assign run_cmd_o = run_q;
   assign error_ack_o = ack_q;

   // ------------------------------------------------------------
   // Output functions
   // ------------------------------------------------------------
   wire [15:0] source = {6'h00, ack_level, run_q, global_error_i, temp_derating_i, derating_i,
                         full_load_i, standby_i, operating_i, 1'b1, 1'b0};

   // Digital ports invert when polarity is low; relays invert when polarity is high
   wire [3:0] invert = {config_q[`CIO_CFG_R2_POL], config_q[`CIO_CFG_R1_POL],
                        !config_q[`CIO_CFG_B_POL], !config_q[`CIO_CFG_A_POL]};
   wire [3:0] drive;

   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : gen_out
         output_drive u_drive (
            .clock_i(clock_i),
            .srst_i(srst_i),
            .source_i(source),
            .select_i(func_q[4*g +: 4]),
            .invert_i(invert[g]),
            .drive_o(drive[g])
         );
      end
   endgenerate

   // Port drives only while set as output; otherwise released
   assign customer_port_a_o = a_dir && drive[0];
   assign customer_port_a_oe_o = a_dir;
   assign customer_port_b_o = b_dir && drive[1];
   assign customer_port_b_oe_o = b_dir;

   // ------------------------------------------------------------
   // Relay outputs
   // ------------------------------------------------------------
   assign relay_output_one_o = drive[2];
   assign relay_output_two_o = drive[3];

   // ------------------------------------------------------------
   // Read port
   // ------------------------------------------------------------
   wire [31:0] status_word = {25'h0, drive[3], drive[2], customer_port_b_o, customer_port_a_o, b_in, a_in, run_q};
   wire [31:0] cfg_word = {26'h0, config_q};
   wire [31:0] func_word = {16'h0, func_q};
   wire [31:0] runsrc_word = {29'h0, runsrc_q};
   wire [31:0] rd_mux = sel_cfg ? cfg_word :
                        sel_func ? func_word :
                        sel_runsrc ? runsrc_word :
                        sel_status ? status_word : 32'h0;

   // Read data is cleared between reads so a stale word never looks fresh
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         rdata_q <= 32'h0;
      end else if (rd_i) begin
         rdata_q <= rd_mux;
      end else begin
         rdata_q <= 32'h0;
      end
   end

   assign rdata_o = rdata_q;

endmodule : customer_io_function_mux

// ---- tb/customer_io_function_mux_props.sv ----
`timescale 1ns/1ps
module cio_props (
   // Clock, reset, bus
   input wire logic clock_i,
   input wire logic srst_i,
   input wire logic [31:0] rdata_o,
   // Status
   input wire logic standby_i,
   input wire logic derating_i,
   input wire logic global_error_i,
   // Pins and commands
   input wire logic customer_port_a_o,
   input wire logic customer_port_a_oe_o,
   input wire logic customer_port_b_o,
   input wire logic customer_port_b_oe_o,
   input wire logic relay_output_one_o,
   input wire logic relay_output_two_o,
   input wire logic run_cmd_o,
   input wire logic error_ack_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (srst_i);
   property p_rst; $fell(srst_i) |-> rdata_o == 32'h0 && !run_cmd_o && !error_ack_o; endproperty
   a_rst: assert property (p_rst) else $error("outputs not idle after reset");
   property p_oe; $fell(srst_i) |-> !customer_port_a_oe_o && customer_port_b_oe_o; endproperty
   a_oe: assert property (p_oe) else $error("port directions wrong after reset");
   property p_defb; $fell(srst_i) |=> customer_port_b_o == $past(derating_i); endproperty
   a_defb: assert property (p_defb) else $error("port b default drive wrong");
   property p_def1; $fell(srst_i) |=> relay_output_one_o == $past(standby_i); endproperty
   a_def1: assert property (p_def1) else $error("relay one default wrong");
   property p_def2; $fell(srst_i) |=> relay_output_two_o != $past(global_error_i); endproperty
   a_def2: assert property (p_def2) else $error("relay two default wrong");
   property p_adrv; !customer_port_a_oe_o && !$past(customer_port_a_oe_o) |-> !customer_port_a_o; endproperty
   a_adrv: assert property (p_adrv) else $error("port a driven while input");
   property p_bdrv; !customer_port_b_oe_o && !$past(customer_port_b_oe_o) |-> !customer_port_b_o; endproperty
   a_bdrv: assert property (p_bdrv) else $error("port b driven while input");
   property p_ack; error_ack_o |=> !error_ack_o; endproperty
   a_ack: assert property (p_ack) else $error("ack longer than one cycle");
   c_ack: cover property (error_ack_o);
   c_run: cover property (run_cmd_o);
   c_both: cover property (relay_output_two_o && customer_port_b_o);
endmodule : cio_props

bind customer_io_function_mux cio_props u_props (
   .clock_i(clock_i),
   .srst_i(srst_i),
   .rdata_o(rdata_o),
   .standby_i(standby_i),
   .derating_i(derating_i),
   .global_error_i(global_error_i),
   .customer_port_a_o(customer_port_a_o),
   .customer_port_a_oe_o(customer_port_a_oe_o),
   .customer_port_b_o(customer_port_b_o),
   .customer_port_b_oe_o(customer_port_b_oe_o),
   .relay_output_one_o(relay_output_one_o),
   .relay_output_two_o(relay_output_two_o),
   .run_cmd_o(run_cmd_o),
   .error_ack_o(error_ack_o)
);

// ---- tb/plant_model.sv ----
`timescale 1ns/1ps
module plant_model (
   input wire logic oe_i,
   input wire logic drv_i,
   input wire logic level_i,
   input wire logic open_i,
   output logic pin_o
);
   // Open wiring reads low, so a loose terminal never looks asserted
   assign pin_o = oe_i ? drv_i : (!open_i && level_i);
endmodule : plant_model

// ---- tb/customer_io_function_mux_tb_top.sv ----
`timescale 1ns/1ps
module customer_io_function_mux_tb_top;
   logic clock_i = 1'h0, srst_i = 1'h1, wr_i = 1'h0, rd_i = 1'h0;
   logic [7:0] addr_i = 8'h00;
   logic [31:0] wdata_i = 32'h0, rdata_o, r;
   logic operating_i = 0, standby_i = 0, full_load_i = 0, derating_i = 0, temp_derating_i = 0;
   logic global_error_i = 0, sync_link_run_i = 0, local_switch_i = 0, lvl_a = 0, lvl_b = 0, opn = 0;
   logic customer_port_a_i, customer_port_a_o, customer_port_a_oe_o;
   logic customer_port_b_i, customer_port_b_o, customer_port_b_oe_o;
   logic relay_output_one_o, relay_output_two_o, run_cmd_o, error_ack_o;
   integer seed = 14283, n_errors = 0, compares = 0, i, k;
   logic [5:0] cfg;
   logic [15:0] fn;
   logic [7:0] st;
   logic e1, e2, ea, eb, erun;
   always #5 clock_i = ~clock_i;
   customer_io_function_mux DUT (
      .clock_i(clock_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
      .rdata_o(rdata_o), .operating_i(operating_i), .standby_i(standby_i), .full_load_i(full_load_i),
      .derating_i(derating_i), .temp_derating_i(temp_derating_i), .global_error_i(global_error_i),
      .sync_link_run_i(sync_link_run_i), .local_switch_i(local_switch_i),
      .customer_port_a_i(customer_port_a_i), .customer_port_a_o(customer_port_a_o),
      .customer_port_a_oe_o(customer_port_a_oe_o), .customer_port_b_i(customer_port_b_i),
      .customer_port_b_o(customer_port_b_o), .customer_port_b_oe_o(customer_port_b_oe_o),
      .relay_output_one_o(relay_output_one_o), .relay_output_two_o(relay_output_two_o),
      .run_cmd_o(run_cmd_o), .error_ack_o(error_ack_o));
   plant_model pa (.oe_i(customer_port_a_oe_o), .drv_i(customer_port_a_o), .level_i(lvl_a), .open_i(opn),
      .pin_o(customer_port_a_i));
   plant_model pb (.oe_i(customer_port_b_oe_o), .drv_i(customer_port_b_o), .level_i(lvl_b), .open_i(1'h0),
      .pin_o(customer_port_b_i));
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : chk
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'h1;
      @(posedge clock_i);
      wr_i <= 1'h0;
   endtask : wr
   task rd(input logic [7:0] a);
      @(posedge clock_i);
      addr_i <= a;
      rd_i <= 1'h1;
      @(posedge clock_i);
      rd_i <= 1'h0;
      #1 r = rdata_o;
   endtask : rd
   // Code 0 and 1 are the constants; 2 to 7 follow the status inputs
   function logic act(input logic [3:0] c);
      act = c < 4'h8 ? st[c[2:0]] : 1'h0;
   endfunction : act
   task print_verdict;
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : print_verdict
   initial begin
      #500000;
      n_errors++;
      print_verdict;
   end
   initial begin
      repeat (20) @(posedge clock_i);
      srst_i <= 1'h0;
      rd(8'h00); chk(r, 32'h2a);
      rd(8'h04); chk(r, 32'h7350);
      rd(8'h08); chk(r, 32'h0);
      wr(8'h10, 32'hffff_ffff);
      rd(8'h10); chk(r, 32'h0);
      rd(8'h00); chk(r, 32'h2a);
      for (i = 0; i < 40; i++) begin
         cfg = 6'($random(seed));
         fn = 16'($random(seed)) & 16'h7777;
         st = {6'($random(seed)), 2'h2};
         wr(8'h00, 32'(cfg));
         wr(8'h04, 32'(fn));
         {global_error_i, temp_derating_i, derating_i, full_load_i, standby_i, operating_i} <= st[7:2];
         repeat (3) @(posedge clock_i);
         #1;
         e1 = act(fn[11:8]) ^ cfg[4];
         e2 = act(fn[15:12]) ^ cfg[5];
         ea = cfg[0] & (act(fn[3:0]) ~^ cfg[2]);
         eb = cfg[1] & (act(fn[7:4]) ~^ cfg[3]);
         chk(32'(relay_output_one_o), 32'(e1));
         chk(32'(relay_output_two_o), 32'(e2));
         chk(32'(customer_port_a_o), 32'(ea));
         chk(32'(customer_port_b_o), 32'(eb));
         chk(32'({customer_port_b_oe_o, customer_port_a_oe_o}), 32'(cfg[1:0]));
         // Inputs idle low and no port selects the run command, so only the drive bits may be set
         rd(8'h0c); chk(r, 32'({e2, e1, eb, ea, 3'h0}));
      end
      wr(8'h00, 32'h0);
      wr(8'h04, 32'h98);
      for (k = 0; k < 20; k++) begin
         wr(8'h08, 32'(k % 5));
         {opn, sync_link_run_i, local_switch_i, lvl_a} <= 4'($random(seed));
         repeat (5) @(posedge clock_i);
         #1;
         erun = k % 5 == 1 || (k % 5 == 0 && lvl_a && !opn) || (k % 5 == 3 && local_switch_i)
            || (k % 5 == 4 && sync_link_run_i);
         chk(32'(run_cmd_o), 32'(erun));
      end
      // Unused source code falls back to the terminal; relay one shows the run state, code 15 reads 0
      wr(8'h08, 32'h7);
      wr(8'h04, 32'hf898);
      repeat (5) @(posedge clock_i);
      #1;
      erun = lvl_a && !opn;
      chk(32'(run_cmd_o), 32'(erun));
      chk(32'(relay_output_one_o), 32'(erun));
      chk(32'(relay_output_two_o), 32'h0);
      repeat (4) @(posedge clock_i);
      lvl_b <= 1'h1;
      k = 0;
      repeat (8) begin
         @(negedge clock_i);
         k += error_ack_o;
      end
      chk(32'(k), 32'h1);
      rd(8'h0c); chk(32'(r[2:1]), 32'({1'h1, erun}));
      // Reset again in mid-run: every setting must fall back to its default
      @(posedge clock_i);
      srst_i <= 1'h1;
      repeat (2) @(posedge clock_i);
      srst_i <= 1'h0;
      rd(8'h00); chk(r, 32'h2a);
      rd(8'h04); chk(r, 32'h7350);
      rd(8'h08); chk(r, 32'h0);
      chk(32'({customer_port_b_oe_o, customer_port_a_oe_o}), 32'h2);
      print_verdict;
   end
endmodule : customer_io_function_mux_tb_top
